// ==== core/serial_shift_regs.svh ====
`ifndef SERIAL_SHIFT_REGS_SVH
`define SERIAL_SHIFT_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SSI_IDX_PIN_MODE    10'h004
`define SSI_IDX_MODE_A      10'h005
`define SSI_IDX_DATA_LOW    10'h006
`define SSI_IDX_DATA_HIGH   10'h007
`define SSI_IDX_MISC        10'h00c
`define SSI_IDX_IRQ_FLAGS   10'h023
`define SSI_IDX_MODE_B      10'h028
`define SSI_IDX_STATUS      10'h030
`define SSI_IDX_START       10'h031

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSI_IRQ_FLAG_BIT    2
`define SSI_MODE_B_RANGE    0
`define SSI_MODE_B_IDLE     1
`define SSI_PIN_OUT_SEL     0
`define SSI_PIN_IN_SEL      1
`define SSI_MISC_PMOS_OFF   2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SSI_RST_PIN_MODE    2'h0
`define SSI_RST_MODE_A      4'h0
`define SSI_RST_MODE_B      2'h0
`define SSI_RST_MISC        4'h0
`define SSI_RST_DATA        8'h00

// ----------------------------------------------------------------------
// Clock source codes and half periods of the shift clock, in pclk cycles
// ----------------------------------------------------------------------
`define SSI_SRC_SYSCLK      3'h6
`define SSI_SRC_EXTERNAL    3'h7
`define SSI_HALF_SYSCLK     13'h0001
`define SSI_HALF_DIV2048    13'h0800
`define SSI_HALF_DIV512     13'h0200
`define SSI_HALF_DIV128     13'h0080
`define SSI_HALF_DIV32      13'h0020
`define SSI_HALF_DIV8       13'h0008
`define SSI_HALF_DIV2       13'h0002
`define SSI_BITS_PER_XFER   3'h7

`endif

// ==== core/serial_shift_pkg.sv ====
package serial_shift_pkg;

  typedef enum logic [1:0] {
    ST_START_WAIT,
    ST_CLK_WAIT,
    ST_XFER,
    ST_CONT
  } ssi_state_t;

  typedef struct packed {
    logic       pin_en;
    logic [2:0] src;
  } mode_a_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic so_out;
    logic so_oe;
  } serial_pins_t;

endpackage : serial_shift_pkg

// ==== core/serial_shift.sv ====
// Overview of operation
// - Each transfer shifts eight bits, sending and receiving through one data register.
// - With mode A bit 3 set, pin mode bits pick clock, transmit, receive or both.
// - Any mode A write initialises the interface whatever its state.
// - Serial output is low after reset until idle level set or a transfer sends data.
// - Start clears the bit counter and counts on each rising shift clock edge.
// - Eighth clock or abort clears the counter, sets the flag, stops shifting.
// - Prescaler codes divide by 2048..2 or 4096..4, period twice the ratio.
// - Reset enters start-wait, ignoring the clock; start enters clock-wait.
// - First falling clock in clock-wait shifts and enters the transfer state.
// - Pin mode 00 with internal clock enters continuous clock instead.
// - Mode A write in clock-wait returns to start-wait.
// - Start during transfer clears the counter and returns to clock-wait.
// - After eight clocks external goes clock-wait, internal stops clock to start-wait.
// - Mode A write during transfer aborts, initialises, enters start-wait.
// - Every exit from transfer sets the serial flag.
// - Continuous clock state drives only the clock and shifts no data.
// - Mode A write in continuous clock stops it and enters start-wait.
// - In idle states output follows the idle level bit, not during transfer.
// - A spurious external clock wraps early, sets flag, next clock re-enters transfer.
// - Clock pin follows mode A, data pins follow pin mode.
// - Software writes transmit data and reads received data in the shift register.
// - Data leaves LSB first on falling edges and enters on rising edges.
`include "serial_shift_regs.svh"

module serial_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  input wire logic si_in,
  output serial_shift_pkg::serial_pins_t pins,
  output logic serial_irq_flag
);
  import serial_shift_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [12:0] half_period(input logic [2:0] sel, input logic range_bit);
    logic [12:0] base;
    base = `SSI_HALF_SYSCLK;
    case (sel)
      3'h0: base = `SSI_HALF_DIV2048;
      3'h1: base = `SSI_HALF_DIV512;
      3'h2: base = `SSI_HALF_DIV128;
      3'h3: base = `SSI_HALF_DIV32;
      3'h4: base = `SSI_HALF_DIV8;
      3'h5: base = `SSI_HALF_DIV2;
      default: base = `SSI_HALF_SYSCLK;
    endcase
    // Range bit doubles every prescaler ratio; system clock is not scaled
    if (range_bit && sel < `SSI_SRC_SYSCLK) begin
      base = {base[11:0], 1'b0};
    end
    return base;
  endfunction : half_period

  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    return addr[11:2] == idx && addr[1:0] == 2'h0;
  endfunction : reg_hit

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  ssi_state_t state_reg, state_next;
  mode_a_t mode_a_reg, mode_a_next;
  logic [1:0] mode_b_reg, mode_b_next;
  logic [1:0] pin_mode_reg, pin_mode_next;
  logic [3:0] misc_reg, misc_next;
  logic [7:0] shreg_reg, shreg_next;
  logic [2:0] cnt_reg, cnt_next;
  logic flag_reg, flag_next;
  logic [12:0] div_reg, div_next;
  logic sck_int_reg, sck_int_next;
  logic sck_prev_reg, sck_prev_next;
  logic so_reg, so_next;
  logic [31:0] prdata_reg, prdata_next;

  logic setup_ph, wr_acc, mapped;
  logic wr_mode_a, wr_start, wr_low, wr_high, flag_clr;
  logic ext_clk, int_clk, clk_run, fall, rise, rx_bit, set_flag;
  logic [12:0] half;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign mapped = reg_hit(paddr, `SSI_IDX_PIN_MODE) || reg_hit(paddr, `SSI_IDX_MODE_A) ||
                  reg_hit(paddr, `SSI_IDX_DATA_LOW) || reg_hit(paddr, `SSI_IDX_DATA_HIGH) ||
                  reg_hit(paddr, `SSI_IDX_MISC) || reg_hit(paddr, `SSI_IDX_IRQ_FLAGS) ||
                  reg_hit(paddr, `SSI_IDX_MODE_B) || reg_hit(paddr, `SSI_IDX_STATUS) ||
                  reg_hit(paddr, `SSI_IDX_START);
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign wr_mode_a = wr_acc && reg_hit(paddr, `SSI_IDX_MODE_A);
  assign wr_start = wr_acc && reg_hit(paddr, `SSI_IDX_START);
  assign wr_low = wr_acc && reg_hit(paddr, `SSI_IDX_DATA_LOW);
  assign wr_high = wr_acc && reg_hit(paddr, `SSI_IDX_DATA_HIGH);
  assign flag_clr = wr_acc && reg_hit(paddr, `SSI_IDX_IRQ_FLAGS) &&
                    !pwdata[`SSI_IRQ_FLAG_BIT];

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always_comb begin
    mode_a_next = mode_a_reg;
    mode_b_next = mode_b_reg;
    pin_mode_next = pin_mode_reg;
    misc_next = misc_reg;
    if (wr_mode_a) begin
      mode_a_next = mode_a_t'(pwdata[3:0]);
    end
    if (wr_acc && reg_hit(paddr, `SSI_IDX_MODE_B)) begin
      mode_b_next = pwdata[1:0];
    end
    if (wr_acc && reg_hit(paddr, `SSI_IDX_PIN_MODE)) begin
      pin_mode_next = pwdata[1:0];
    end
    if (wr_acc && reg_hit(paddr, `SSI_IDX_MISC)) begin
      misc_next = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a_reg <= mode_a_t'(`SSI_RST_MODE_A);
      mode_b_reg <= `SSI_RST_MODE_B;
      pin_mode_reg <= `SSI_RST_PIN_MODE;
      misc_reg <= `SSI_RST_MISC;
    end else if (clk_en) begin
      mode_a_reg <= mode_a_next;
      mode_b_reg <= mode_b_next;
      pin_mode_reg <= pin_mode_next;
      misc_reg <= misc_next;
    end
  end

  // --------------------------------------------------------------------
  // Read data, captured in the setup phase so it is a flop output
  // --------------------------------------------------------------------
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_ph && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (reg_hit(paddr, `SSI_IDX_DATA_LOW)) begin
        prdata_next[3:0] = shreg_reg[3:0];
      end else if (reg_hit(paddr, `SSI_IDX_DATA_HIGH)) begin
        prdata_next[3:0] = shreg_reg[7:4];
      end else if (reg_hit(paddr, `SSI_IDX_IRQ_FLAGS)) begin
        prdata_next[`SSI_IRQ_FLAG_BIT] = flag_reg;
      end else if (reg_hit(paddr, `SSI_IDX_STATUS)) begin
        prdata_next[6:0] = {sck_in, sck_int_reg, cnt_reg, state_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // --------------------------------------------------------------------
  // Shift clock source
  // --------------------------------------------------------------------
  assign ext_clk = mode_a_reg.pin_en && mode_a_reg.src == `SSI_SRC_EXTERNAL;
  assign int_clk = mode_a_reg.pin_en && mode_a_reg.src != `SSI_SRC_EXTERNAL;
  assign half = half_period(mode_a_reg.src, mode_b_reg[`SSI_MODE_B_RANGE]);
  // Clock runs only while a transfer is pending, busy or continuous
  assign clk_run = int_clk && state_reg != ST_START_WAIT;
  assign rx_bit = pin_mode_reg[`SSI_PIN_IN_SEL] ? si_in : 1'b0;

  // --------------------------------------------------------------------
  // Transfer engine
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shreg_next = shreg_reg;
    flag_next = flag_reg;
    div_next = div_reg;
    sck_int_next = sck_int_reg;
    so_next = so_reg;
    sck_prev_next = sck_in;
    set_flag = 1'b0;
    fall = 1'b0;
    rise = 1'b0;

    // Divider toggles every half period, giving a period of twice the ratio
    if (clk_run) begin
      if (div_reg >= half - 13'h0001) begin
        div_next = 13'h0000;
        sck_int_next = !sck_int_reg;
        fall = sck_int_reg;
        rise = !sck_int_reg;
      end else begin
        div_next = div_reg + 13'h0001;
      end
    end else begin
      div_next = 13'h0000;
      sck_int_next = 1'b1;
    end
    if (ext_clk) begin
      fall = sck_prev_reg && !sck_in;
      rise = !sck_prev_reg && sck_in;
    end

    case (state_reg)
      ST_START_WAIT: begin
        // Shift clock edges are ignored here
        if (wr_start) begin
          cnt_next = 3'h0;
          state_next = ST_CLK_WAIT;
        end
      end
      ST_CLK_WAIT: begin
        if (wr_start) begin
          cnt_next = 3'h0;
        end else if (fall) begin
          if (int_clk && pin_mode_reg == 2'h0) begin
            state_next = ST_CONT;
          end else begin
            so_next = shreg_reg[0];
            state_next = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (wr_start) begin
          cnt_next = 3'h0;
          set_flag = 1'b1;
          state_next = ST_CLK_WAIT;
        end else begin
          if (fall) begin
            so_next = shreg_reg[0];
          end
          if (rise) begin
            shreg_next = {rx_bit, shreg_reg[7:1]};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `SSI_BITS_PER_XFER) begin
              cnt_next = 3'h0;
              set_flag = 1'b1;
              // Internal clock stops on the eighth pulse; external waits for more
              state_next = int_clk ? ST_START_WAIT : ST_CLK_WAIT;
            end
          end
        end
      end
      ST_CONT: begin
        // Clock only, no shifting
        state_next = ST_CONT;
      end
      default: begin
        state_next = ST_START_WAIT;
      end
    endcase

    // Mode A write wins over everything and re-initialises the engine
    if (wr_mode_a) begin
      state_next = ST_START_WAIT;
      cnt_next = 3'h0;
      div_next = 13'h0000;
      sck_int_next = 1'b1;
      if (state_reg == ST_XFER) begin
        set_flag = 1'b1;
      end
    end

    if (state_next == ST_START_WAIT || state_next == ST_CLK_WAIT) begin
      so_next = mode_b_reg[`SSI_MODE_B_IDLE];
    end

    // Software loads are undefined mid transfer; later write simply wins
    if (wr_low) begin
      shreg_next[3:0] = pwdata[3:0];
    end
    if (wr_high) begin
      shreg_next[7:4] = pwdata[3:0];
    end

    // A set in the same cycle as a clear is kept
    if (set_flag) begin
      flag_next = 1'b1;
    end else if (flag_clr) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_START_WAIT;
      cnt_reg <= 3'h0;
      shreg_reg <= `SSI_RST_DATA;
      flag_reg <= 1'b0;
      div_reg <= 13'h0000;
      sck_int_reg <= 1'b1;
      sck_prev_reg <= 1'b1;
      so_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shreg_reg <= shreg_next;
      flag_reg <= flag_next;
      div_reg <= div_next;
      sck_int_reg <= sck_int_next;
      sck_prev_reg <= sck_prev_next;
      so_reg <= so_next;
    end
  end

  // --------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------
  always_comb begin
    pins.sck_out = sck_int_reg;
    pins.sck_oe = int_clk;
    pins.so_out = so_reg;
    // PMOS off turns the output into an open-drain pull-down
    pins.so_oe = pin_mode_reg[`SSI_PIN_OUT_SEL] &&
                 !(misc_reg[`SSI_MISC_PMOS_OFF] && so_reg);
  end

  assign serial_irq_flag = flag_reg;

endmodule : serial_shift

// ==== tb/serial_shift_assertions.sv ====
`include "serial_shift_regs.svh"

module serial_shift_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sck_in,
  input wire logic si_in,
  input wire serial_shift_pkg::serial_pins_t pins,
  input wire logic serial_irq_flag
);
  import serial_shift_pkg::*;
  logic [9:0] idx;
  logic wr, rd, wo, known, clr;
  logic [3:0] ma, mc;
  logic [1:0] pm, mb;
  assign idx = paddr[11:2];
  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && !penable && !pwrite && clk_en;
  assign wo = idx inside {`SSI_IDX_PIN_MODE, `SSI_IDX_MODE_A, `SSI_IDX_MISC, `SSI_IDX_MODE_B};
  assign known = paddr[1:0] == 2'h0 && (wo || idx inside {`SSI_IDX_DATA_LOW,
    `SSI_IDX_DATA_HIGH, `SSI_IDX_IRQ_FLAGS, `SSI_IDX_STATUS, `SSI_IDX_START});
  assign clr = wr && idx == `SSI_IDX_IRQ_FLAGS && !pwdata[`SSI_IRQ_FLAG_BIT];
  // ----
  // Shadows of the write-only controls
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ma <= `SSI_RST_MODE_A;
      mc <= `SSI_RST_MISC;
      pm <= `SSI_RST_PIN_MODE;
      mb <= `SSI_RST_MODE_B;
    end else if (wr) begin
      if (idx == `SSI_IDX_MODE_A) ma <= pwdata[3:0];
      if (idx == `SSI_IDX_MISC) mc <= pwdata[3:0];
      if (idx == `SSI_IDX_PIN_MODE) pm <= pwdata[1:0];
      if (idx == `SSI_IDX_MODE_B) mb <= pwdata[1:0];
    end
  end
  default clocking ck @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_slverr_cause: assert property (pslverr == (psel && penable && !known))
    else $error("pslverr wrong");
  a_zero_read: assert property (rd && (wo || !known) |=> prdata == 32'h0)
    else $error("read data not zero");
  a_prdata_hold: assert property (!rd |=> $stable(prdata))
    else $error("read data moved");
  a_flag_clear: assert property ($fell(serial_irq_flag) |-> $past(clr))
    else $error("flag fell without clear");
  a_sck_drive: assert property (pins.sck_oe == (ma[3] && ma[2:0] != `SSI_SRC_EXTERNAL))
    else $error("clock pin enable wrong");
  a_so_enable: assert property (pins.so_oe == (pm[0] && !(mc[2] && pins.so_out)))
    else $error("data pin enable wrong");
  a_sck_stop: assert property (wr && idx == `SSI_IDX_MODE_A |-> ##2 pins.sck_out [*2])
    else $error("clock not stopped high");
  a_so_idle: assert property (wr && idx == `SSI_IDX_MODE_B |-> ##[1:2] pins.so_out == mb[1])
    else $error("idle level not shown");
endmodule : serial_shift_assertions

// ==== tb/serial_peer.sv ====
module serial_peer (
  input wire logic pclk,
  input wire logic sck,
  input wire logic so,
  input wire logic go,
  input wire logic [3:0] pulses,
  input wire logic [7:0] tx,
  output logic sck_drv,
  output logic si,
  output logic [7:0] rx
);
  logic sck_q, so_q, first, noise;
  logic [4:0] halves;
  logic [1:0] tmr;
  logic [2:0] bi;
  logic [3:0] high_cnt;
  logic [7:0] txs;
  // Line is let go once the clock has rested high a while
  assign si = (high_cnt == 4'hf) ? noise : txs[bi];
  initial begin
    {sck_q, sck_drv, first} = 3'h7;
    {so_q, noise, halves, tmr, bi, high_cnt, txs, rx} = '0;
  end
  always @(posedge pclk) begin
    sck_q <= sck;
    so_q <= so;
    noise <= ~noise;
    high_cnt <= !sck ? 4'h0 : (high_cnt == 4'hf) ? high_cnt : high_cnt + 4'h1;
    if (go) begin
      halves <= {pulses, 1'h0};
      txs <= tx;
      bi <= 3'h0;
      first <= 1'h1;
      tmr <= 2'h0;
    end else if (halves != 5'h0) begin
      tmr <= (tmr == 2'h2) ? 2'h0 : tmr + 2'h1;
      if (tmr == 2'h2) begin
        sck_drv <= ~sck_drv;
        halves <= halves - 5'h1;
      end
    end
    // Bit changes only after a fall, so it holds across the device's rise
    if (sck_q && !sck) begin
      first <= 1'h0;
      if (!first) bi <= bi + 3'h1;
    end
    // Take the line as it stood at the rise, not what the same edge launched
    if (!sck_q && sck) rx <= {so_q, rx[7:1]};
  end
endmodule : serial_peer

// ==== tb/serial_shift_tb.sv ====
`include "serial_shift_regs.svh"

module serial_shift_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_shift_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic clk_en = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic go = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pulses = 4'h0;
  logic [7:0] tx = 8'h0;
  logic slv, pready, pslverr, flag, sck_drv, sck_line, si;
  logic [31:0] prdata, rd;
  logic [7:0] rx, v;
  serial_pins_t pins;
  int failures = 0;
  int checked = 0;
  int n, a, b;
  always #20 pclk = ~pclk;
  assign sck_line = pins.sck_oe ? pins.sck_out : sck_drv;
  serial_shift uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_line), .si_in(si), .pins(pins),
    .serial_irq_flag(flag));
  serial_peer peer (.pclk(pclk), .sck(sck_line), .so(pins.so_out), .go(go),
    .pulses(pulses), .tx(tx), .sck_drv(sck_drv), .si(si), .rx(rx));
  // ----
  // Shared tasks
  // ----
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic stop_run;
    failures++;
    $display("Error wait expected done seen timeout");
    give_verdict();
  endtask : stop_run
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) stop_run();
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic await(input int s, input logic lvl, output int cnt);
    cnt = 0;
    while ((s == 0 ? flag : s == 1 ? pins.sck_out : sck_line) !== lvl) begin
      @(posedge pclk);
      cnt++;
      if (cnt > 9000) stop_run();
    end
  endtask : await
  task automatic get_data;
    apb(1'h0, `SSI_IDX_DATA_LOW, 32'h0);
    v[3:0] = rd[3:0];
    apb(1'h0, `SSI_IDX_DATA_HIGH, 32'h0);
    v[7:4] = rd[3:0];
  endtask : get_data
  // Start goes out before the peer clocks, since start-wait ignores edges
  task automatic xfer(input logic [3:0] ma, input logic [7:0] d, input logic [3:0] np);
    apb(1'h1, `SSI_IDX_MODE_A, {28'h0, ma});
    apb(1'h1, `SSI_IDX_DATA_LOW, {28'h0, d[3:0]});
    apb(1'h1, `SSI_IDX_DATA_HIGH, {28'h0, d[7:4]});
    apb(1'h1, `SSI_IDX_IRQ_FLAGS, 32'h0);
    apb(1'h1, `SSI_IDX_START, 32'h0);
    @(posedge pclk);
    tx <= ~d;
    pulses <= np;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    if (ma[2:0] == 3'h7) check("after start", rd[4:0], 5'h01);
  endtask : xfer
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    check("sck_out", pins.sck_out, 1'h1);
    check("flag", flag, 1'h0);
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("status", rd[4:0], 5'h0);
    apb(1'h0, `SSI_IDX_MODE_A, 32'h0);
    check("wo read", rd, 32'h0);
    apb(1'h0, 10'h3ff, 32'h0);
    check("slverr", slv, 1'h1);
  endtask : t_reset
  task automatic t_idle;
    apb(1'h1, `SSI_IDX_PIN_MODE, 32'h1);
    apb(1'h1, `SSI_IDX_MISC, 32'h4);
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, `SSI_IDX_MODE_B, {30'h0, !i[0], 1'h0});
      repeat (2) @(posedge pclk);
      check("idle level", pins.so_out, !i[0]);
      check("so enable", pins.so_oe, i[0]);
    end
    // A write while the block is frozen must leave no trace
    clk_en <= 1'h0;
    apb(1'h1, `SSI_IDX_MODE_B, 32'h2);
    clk_en <= 1'h1;
    repeat (2) @(posedge pclk);
    check("frozen write", pins.so_out, 1'h0);
  endtask : t_idle
  task automatic t_ext;
    apb(1'h1, `SSI_IDX_PIN_MODE, 32'h3);
    xfer(4'hf, 8'hc5, 4'h8);
    await(0, 1'h1, n);
    check("peer rx", rx, 8'hc5);
    get_data();
    check("device rx", v, 8'h3a);
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("ext end", rd[4:0], 5'h01);
  endtask : t_ext
  task automatic t_int;
    for (int m = 1; m < 4; m++) begin
      apb(1'h1, `SSI_IDX_PIN_MODE, m);
      xfer(4'hc, 8'h9a, 4'h0);
      await(0, 1'h1, n);
      get_data();
      check("device rx", v, m[1] ? 8'h65 : 8'h00);
      if (m[0]) check("peer rx", rx, 8'h9a);
      apb(1'h0, `SSI_IDX_STATUS, 32'h0);
      check("int end", rd[5:0], 6'h20);
    end
  endtask : t_int
  task automatic t_cont;
    apb(1'h1, `SSI_IDX_PIN_MODE, 32'h0);
    xfer(4'he, 8'h33, 4'h0);
    for (int i = 0; i < 10; i++) begin
      await(1, 1'h0, n);
      await(1, 1'h1, n);
    end
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("cont state", rd[1:0], 2'h3);
    get_data();
    check("cont data", v, 8'h33);
    apb(1'h1, `SSI_IDX_MODE_A, 32'he);
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("cont stop", {flag, rd[1:0]}, 3'h0);
  endtask : t_cont
  task automatic t_restart;
    apb(1'h1, `SSI_IDX_PIN_MODE, 32'h3);
    xfer(4'hf, 8'h0f, 4'h3);
    for (int i = 0; i < 3; i++) begin
      await(2, 1'h0, n);
      await(2, 1'h1, n);
    end
    apb(1'h1, `SSI_IDX_START, 32'h0);
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("restart", {flag, rd[4:0]}, 6'h21);
    apb(1'h1, `SSI_IDX_MODE_A, 32'hf);
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("wait cancel", rd[1:0], 2'h0);
    xfer(4'hf, 8'h0f, 4'h9);
    await(0, 1'h1, n);
    await(2, 1'h0, n);
    await(2, 1'h1, n);
    apb(1'h0, `SSI_IDX_STATUS, 32'h0);
    check("extra pulse", rd[1:0], 2'h2);
    apb(1'h1, `SSI_IDX_IRQ_FLAGS, 32'h0);
    @(posedge pclk);
    check("flag clear", flag, 1'h0);
    apb(1'h1, `SSI_IDX_MODE_A, 32'hf);
    @(posedge pclk);
    check("error seen", flag, 1'h1);
  endtask : t_restart
  task automatic t_rates;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 7; c++) begin
        apb(1'h1, `SSI_IDX_MODE_B, r);
        xfer(4'h8 | c[3:0], 8'h00, 4'h0);
        await(1, 1'h0, n);
        await(1, 1'h1, a);
        await(1, 1'h0, b);
        check("period", a + b, c == 6 ? 2 : (4096 << r) >> (2 * c));
        await(1, 1'h1, n);
        apb(1'h1, `SSI_IDX_MODE_A, 4'h8 | c[3:0]);
        apb(1'h0, `SSI_IDX_STATUS, 32'h0);
        check("abort", {flag, rd[4:0]}, 6'h20);
      end
    end
  endtask : t_rates
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_idle();
    t_ext();
    t_int();
    t_cont();
    t_restart();
    t_rates();
    give_verdict();
  end
endmodule : serial_shift_tb

bind serial_shift serial_shift_assertions chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
  .si_in(si_in), .pins(pins), .serial_irq_flag(serial_irq_flag));
